// ---- rtl/mps_pkg.sv ----
package mps_pkg;
  // One-second and one-hundredth-second time base
  localparam int unsigned CLOCK_HZ = 100_000_000;
  localparam int unsigned CS_PER_S = 100;
  localparam int unsigned CS_CYCLES = CLOCK_HZ / CS_PER_S;
  localparam logic [6:0] CS_LAST = 7'(CS_PER_S - 1);
  // Fixed delays in seconds; THERMAL_CLEAR_MIN in minutes
  localparam logic [6:0] PHASE_LOSS_S = 7'h01;
  localparam logic [6:0] EXT_FAULT_S = 7'h02;
  localparam logic [6:0] AUTO_RESET_S = 7'h3C;
  localparam int unsigned THERMAL_CLEAR_MIN = 15;
  localparam logic [9:0] THERMAL_CLEAR_S = 10'(THERMAL_CLEAR_MIN * 60);
  // Fixed limits
  localparam logic [7:0] HEATSINK_MAX_C = 8'h55;
  localparam logic [7:0] FREQ_MIN_HZ = 8'h2D;
  localparam logic [7:0] FREQ_MAX_HZ = 8'h41;
  // Setting ranges, in 9 bits except CS_PER_DS in 8 bits
  localparam logic [8:0] UV_MIN_PCT = 9'h032;
  localparam logic [8:0] UV_MAX_PCT = 9'h05A;
  localparam logic [8:0] OV_MIN_PCT = 9'h06E;
  localparam logic [8:0] OV_MAX_PCT = 9'h07D;
  localparam logic [8:0] DELAY_MIN_S = 9'h001;
  localparam logic [8:0] DELAY_MAX_S = 9'h00A;
  localparam logic [8:0] PULSE_MIN_DS = 9'h001;
  localparam logic [8:0] PULSE_MAX_DS = 9'h00A;
  localparam logic [7:0] CS_PER_DS = 8'h0A;
  localparam logic [8:0] PULSE_PCT = 9'h050;
  localparam logic [8:0] INIT_V_MIN_PCT = 9'h00A;
  localparam logic [8:0] INIT_V_MAX_PCT = 9'h032;
  localparam logic [8:0] INIT_I_MIN_PCT = 9'h064;
  localparam logic [8:0] INIT_I_MAX_PCT = 9'h190;
  // Thermal model: current in percent of full load, squared per hundredth second
  localparam int unsigned OL_REF_PCT = 500;
  localparam int unsigned FLA_PCT = 100;
  localparam logic [31:0] HEAT_PER_S = 32'(OL_REF_PCT * OL_REF_PCT * CS_PER_S);
  localparam logic [31:0] COOL_PER_CS = 32'(FLA_PCT * FLA_PCT);
  // Fault causes
  localparam logic [3:0] C_NONE = 4'h0;
  localparam logic [3:0] C_OVERLOAD = 4'h1;
  localparam logic [3:0] C_UNDERVOLT = 4'h2;
  localparam logic [3:0] C_ZEROVOLT = 4'h3;
  localparam logic [3:0] C_OVERVOLT = 4'h4;
  localparam logic [3:0] C_PHASE_LOSS = 4'h5;
  localparam logic [3:0] C_FREQUENCY = 4'h6;
  localparam logic [3:0] C_SEQUENCE = 4'h7;
  localparam logic [3:0] C_WIRING = 4'h8;
  localparam logic [3:0] C_HEATSINK = 4'h9;
  localparam logic [3:0] C_EXTERNAL = 4'hA;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } store_st_t;

  function automatic logic [8:0] clamp9(input logic [8:0] v, input logic [8:0] lo,
                                        input logic [8:0] hi);
    clamp9 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
endpackage

// ---- rtl/held_delay_timer.sv ----
`timescale 1ns/10ps
module held_delay_timer (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_tick,
  input wire logic i_cond,
  input wire logic [6:0] i_limit,
  output logic o_expired
);
  typedef struct packed {
    logic [6:0] cnt;
    logic done;
  } tmr_t;
  tmr_t q, d;

  always_comb begin
    d = q;
    if (!i_cond) begin
      d.cnt = 7'h00;
      d.done = 1'b0;
    end else if (i_tick && !q.done) begin
      d.cnt = 7'(q.cnt + 7'h01);
      d.done = (7'(q.cnt + 7'h01) > i_limit);
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_expired = q.done;

  chk_timer_restart: assert property (@(posedge i_clock) disable iff (!i_nrst)
    !i_cond |=> !o_expired && q.cnt == 7'h00)
    else $error("timer did not restart when condition cleared");
endmodule

// ---- rtl/motor_protection_fault_supervisor.sv ----
`timescale 1ns/10ps
// Functional notes
// - Overload protection armed only in full-voltage run, not during soft start or stop.
// - Thermal accumulator integrates heating minus cooling; trips when full.
// - Accumulator clears after fifteen continuous minutes stopped.
// - Overload delay 1-10 s sets trip time at five times full-load current.
// - After start, trip if voltage below 50-90% threshold longer than delay.
// - Under- and over-voltage delays each set from 1 to 10 s.
// - After start, zero mains voltage trips at once, ignoring the under-voltage delay.
// - Over-voltage 110-125% trip after delay; threshold never below under-voltage setting.
// - Locked parameters refuse a store and show the lock refusal message.
// - No parameter store while ramping.
// - Store attempt ends with save confirmation or save failure message.
// - Energized unit trips when phases missing more than one second.
// - Trip when mains frequency below 45 Hz or above 65 Hz.
// - Phase sequence trip only when enabled, then whenever energized.
// - After start, trip on wiring fault, open winding or shorted thyristor.
// - Trip when heatsink exceeds 85 degrees Celsius.
// - Auxiliary input as external fault trips when closed over two seconds.
// - Any trip latches fault: firing inhibited, indicator, cause shown, relay on.
// - Fault cleared by key or remote input after cause gone; never with start.
// - A fault latched before outage is restored when supply returns.
// - Auto-reset clears under-voltage, zero-voltage and phase faults 60 s after restoration, no start.
// - Nonzero pulse time gives 80% kick without current limit for 0.1-1 s.
// - Initial voltage 10-50%; beyond maximum becomes initial current 100-400%.
module motor_protection_fault_supervisor #(
  parameter int unsigned CS_CYCLES_P = mps_pkg::CS_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_energized,
  input wire logic i_start,
  input wire logic i_ramp_active,
  input wire logic i_run,
  input wire logic [7:0] i_line_pct,
  input wire logic [7:0] i_freq_hz,
  input wire logic i_phase_missing,
  input wire logic i_seq_wrong,
  input wire logic i_seq_enable,
  input wire logic i_wiring_fault,
  input wire logic [7:0] i_heatsink_c,
  input wire logic [9:0] i_current_pct,
  input wire logic i_aux_closed,
  input wire logic i_aux_ext_fault_mode,
  input wire logic i_aux_remote_reset_mode,
  input wire logic i_reset_key,
  input wire logic i_auto_reset_en,
  input wire logic [3:0] i_saved_cause,
  input wire logic [3:0] i_ol_delay_s,
  input wire logic [7:0] i_uv_pct,
  input wire logic [3:0] i_uv_delay_s,
  input wire logic [7:0] i_ov_pct,
  input wire logic [3:0] i_ov_delay_s,
  input wire logic i_lock,
  input wire logic i_store_req,
  input wire logic i_store_done,
  input wire logic i_store_ok,
  input wire logic [3:0] i_pulse_ds,
  input wire logic [7:0] i_init_v_pct,
  input wire logic [8:0] i_init_i_pct,
  output logic [3:0] o_fault_cause,
  output logic o_fault_led,
  output logic o_fault_relay,
  output logic o_fire_inhibit,
  output logic [31:0] o_thermal,
  output logic o_store_write,
  output logic o_save_ok_message,
  output logic o_save_failure_message,
  output logic o_lock_refusal_message,
  output logic o_ramp_refusal_message,
  output logic [8:0] o_voltage_ref_pct,
  output logic o_current_limit_off,
  output logic o_init_current_mode,
  output logic [8:0] o_init_current_pct
);
  import mps_pkg::*;

  typedef struct packed {
    logic [3:0] cause;
    logic restored;
    logic start_q;
    logic [31:0] cs_cnt;
    logic [6:0] cs_in_s;
    logic [31:0] thermal;
    logic [9:0] stop_s;
    logic [7:0] pulse_cs;
    logic pulse_on;
    store_st_t st;
    logic write;
    logic ok;
    logic fail;
    logic lock_msg;
    logic ramp_msg;
    logic [8:0] vref;
    logic lim_off;
    logic icur_mode;
    logic [8:0] icur;
  } state_t;
  state_t q, d;

  logic cs_tick, s_tick;
  logic [8:0] ol_s, uv_eff, ov_eff, uv_dly, ov_dly, pulse_ds;
  logic [31:0] th_full, heat, th_sum;
  logic stopped, ol_trip, uv_low, zero_trip, ov_high, ph_cond, freq_trip;
  logic seq_trip, wire_trip, heat_trip, ext_cond, ar_cond, reset_req, auto_ok;
  logic uv_done, ov_done, ph_done, ext_done, ar_done, still;
  logic [3:0] trip_cause;

  assign cs_tick = (q.cs_cnt == CS_CYCLES_P - 1);
  assign s_tick = cs_tick && (q.cs_in_s == CS_LAST);

  // Settings held inside their ranges
  assign ol_s = clamp9({5'h00, i_ol_delay_s}, DELAY_MIN_S, DELAY_MAX_S);
  assign uv_dly = clamp9({5'h00, i_uv_delay_s}, DELAY_MIN_S, DELAY_MAX_S);
  assign ov_dly = clamp9({5'h00, i_ov_delay_s}, DELAY_MIN_S, DELAY_MAX_S);
  assign uv_eff = clamp9({1'b0, i_uv_pct}, UV_MIN_PCT, UV_MAX_PCT);
  assign ov_eff = clamp9({1'b0, i_ov_pct}, (uv_eff > OV_MIN_PCT) ? uv_eff : OV_MIN_PCT,
                         OV_MAX_PCT);
  assign pulse_ds = clamp9({5'h00, i_pulse_ds}, PULSE_MIN_DS, PULSE_MAX_DS);

  // Thermal model
  assign th_full = 32'(32'(ol_s) * HEAT_PER_S);
  assign heat = 32'(32'(i_current_pct) * 32'(i_current_pct));
  assign th_sum = 32'(q.thermal + heat);
  assign stopped = !i_start && !i_run && !i_ramp_active;
  assign ol_trip = i_run && (q.thermal >= th_full);

  // Trip conditions
  assign zero_trip = i_start && (i_line_pct == 8'h00);
  assign uv_low = i_start && (i_line_pct != 8'h00) && ({1'b0, i_line_pct} < uv_eff);
  assign ov_high = i_energized && ({1'b0, i_line_pct} > ov_eff);
  assign ph_cond = i_energized && i_phase_missing;
  assign freq_trip = i_energized && (i_line_pct != 8'h00)
                     && ((i_freq_hz < FREQ_MIN_HZ) || (i_freq_hz > FREQ_MAX_HZ));
  assign seq_trip = i_energized && i_seq_enable && i_seq_wrong;
  assign wire_trip = i_start && i_wiring_fault;
  assign heat_trip = (i_heatsink_c > HEATSINK_MAX_C);
  assign ext_cond = i_energized && i_aux_ext_fault_mode && i_aux_closed;
  assign ar_cond = i_energized && !i_start && !i_phase_missing
                   && ({1'b0, i_line_pct} >= uv_eff);

  held_delay_timer u_uv (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_tick(s_tick), .i_cond(uv_low),
    .i_limit(7'(uv_dly)), .o_expired(uv_done)
  );
  held_delay_timer u_ov (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_tick(s_tick), .i_cond(ov_high),
    .i_limit(7'(ov_dly)), .o_expired(ov_done)
  );
  held_delay_timer u_ph (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_tick(s_tick), .i_cond(ph_cond),
    .i_limit(PHASE_LOSS_S), .o_expired(ph_done)
  );
  held_delay_timer u_ext (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_tick(s_tick), .i_cond(ext_cond),
    .i_limit(EXT_FAULT_S), .o_expired(ext_done)
  );
  held_delay_timer u_ar (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_tick(s_tick), .i_cond(ar_cond),
    .i_limit(AUTO_RESET_S), .o_expired(ar_done)
  );

  // Trip priority and cause presence
  always_comb begin
    trip_cause = C_NONE;
    if (zero_trip) begin
      trip_cause = C_ZEROVOLT;
    end else if (heat_trip) begin
      trip_cause = C_HEATSINK;
    end else if (wire_trip) begin
      trip_cause = C_WIRING;
    end else if (ph_done) begin
      trip_cause = C_PHASE_LOSS;
    end else if (freq_trip) begin
      trip_cause = C_FREQUENCY;
    end else if (seq_trip) begin
      trip_cause = C_SEQUENCE;
    end else if (uv_done) begin
      trip_cause = C_UNDERVOLT;
    end else if (ov_done) begin
      trip_cause = C_OVERVOLT;
    end else if (ext_done) begin
      trip_cause = C_EXTERNAL;
    end else if (ol_trip) begin
      trip_cause = C_OVERLOAD;
    end
    case (q.cause)
      C_OVERLOAD: still = i_run && (q.thermal >= th_full);
      C_UNDERVOLT: still = uv_low;
      C_ZEROVOLT: still = zero_trip;
      C_OVERVOLT: still = ov_high;
      C_PHASE_LOSS: still = ph_cond;
      C_FREQUENCY: still = freq_trip;
      C_SEQUENCE: still = seq_trip;
      C_WIRING: still = wire_trip;
      C_HEATSINK: still = heat_trip;
      C_EXTERNAL: still = ext_cond;
      default: still = 1'b0;
    endcase
  end

  assign reset_req = i_reset_key || (i_aux_remote_reset_mode && i_aux_closed);
  assign auto_ok = i_auto_reset_en && ar_done
                   && ((q.cause == C_UNDERVOLT) || (q.cause == C_ZEROVOLT)
                   || (q.cause == C_PHASE_LOSS));

  always_comb begin
    d = q;
    d.start_q = i_start;
    d.write = 1'b0;
    // Time base
    d.cs_cnt = cs_tick ? 32'h0000_0000 : 32'(q.cs_cnt + 32'h0000_0001);
    if (s_tick) begin
      d.cs_in_s = 7'h00;
    end else if (cs_tick) begin
      d.cs_in_s = 7'(q.cs_in_s + 7'h01);
    end
    // Stopped time
    if (!stopped) begin
      d.stop_s = 10'h000;
    end else if (s_tick && (q.stop_s != THERMAL_CLEAR_S)) begin
      d.stop_s = 10'(q.stop_s + 10'h001);
    end
    // Thermal accumulator
    if (q.stop_s == THERMAL_CLEAR_S) begin
      d.thermal = 32'h0000_0000;
    end else if (cs_tick) begin
      if (i_run && (th_sum > COOL_PER_CS)) begin
        d.thermal = (th_sum - COOL_PER_CS > th_full) ? th_full : 32'(th_sum - COOL_PER_CS);
      end else if (!i_run && (q.thermal > COOL_PER_CS)) begin
        d.thermal = 32'(q.thermal - COOL_PER_CS);
      end else begin
        d.thermal = 32'h0000_0000;
      end
    end
    // Fault latch
    if (!q.restored) begin
      d.restored = 1'b1;
      d.cause = i_saved_cause;
    end else if (q.cause == C_NONE) begin
      d.cause = trip_cause;
    end else if (!i_start && ((reset_req && !still) || auto_ok)) begin
      d.cause = C_NONE;
    end
    // Pulse start
    if (!i_start) begin
      d.pulse_on = 1'b0;
      d.pulse_cs = 8'h00;
    end else if (i_start && !q.start_q && (i_pulse_ds != 4'h0) && (q.cause == C_NONE)) begin
      d.pulse_on = 1'b1;
      d.pulse_cs = 8'(8'(pulse_ds) * CS_PER_DS);
    end else if (q.pulse_on && cs_tick) begin
      d.pulse_cs = 8'(q.pulse_cs - 8'h01);
      d.pulse_on = (q.pulse_cs != 8'h01);
    end
    // Initial voltage or current
    d.icur_mode = ({1'b0, i_init_v_pct} > INIT_V_MAX_PCT);
    d.icur = clamp9(i_init_i_pct, INIT_I_MIN_PCT, INIT_I_MAX_PCT);
    d.lim_off = d.pulse_on;
    if (d.pulse_on) begin
      d.vref = PULSE_PCT;
    end else begin
      d.vref = clamp9({1'b0, i_init_v_pct}, INIT_V_MIN_PCT, INIT_V_MAX_PCT);
    end
    // Parameter store
    case (q.st)
      ST_IDLE: begin
        if (i_store_req) begin
          d.ok = 1'b0;
          d.fail = 1'b0;
          d.lock_msg = 1'b0;
          d.ramp_msg = 1'b0;
          if (i_lock) begin
            d.lock_msg = 1'b1;
          end else if (i_ramp_active) begin
            d.ramp_msg = 1'b1;
          end else begin
            d.write = 1'b1;
            d.st = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (i_store_done) begin
          d.ok = i_store_ok;
          d.fail = !i_store_ok;
          d.st = ST_IDLE;
        end
      end
      default: d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.vref <= INIT_V_MIN_PCT;
      q.icur <= INIT_I_MIN_PCT;
    end else begin
      q <= d;
    end
  end

  assign o_fault_cause = q.cause;
  assign o_fault_led = (q.cause != C_NONE);
  assign o_fault_relay = (q.cause != C_NONE);
  assign o_fire_inhibit = (q.cause != C_NONE);
  assign o_thermal = q.thermal;
  assign o_store_write = q.write;
  assign o_save_ok_message = q.ok;
  assign o_save_failure_message = q.fail;
  assign o_lock_refusal_message = q.lock_msg;
  assign o_ramp_refusal_message = q.ramp_msg;
  assign o_voltage_ref_pct = q.vref;
  assign o_current_limit_off = q.lim_off;
  assign o_init_current_mode = q.icur_mode;
  assign o_init_current_pct = q.icur;

  chk_no_ol_soft: assert property (@(posedge i_clock) disable iff (!i_nrst)
    q.restored && q.cause == C_NONE && !i_run |=> q.cause != C_OVERLOAD)
    else $error("overload trip outside run");
  chk_thermal_clear: assert property (@(posedge i_clock) disable iff (!i_nrst)
    q.stop_s == THERMAL_CLEAR_S |=> q.thermal == 32'h0000_0000)
    else $error("thermal not cleared after stop interval");
  chk_thermal_cap: assert property (@(posedge i_clock) disable iff (!i_nrst)
    i_run && cs_tick && $stable(th_full) |=> q.thermal <= th_full)
    else $error("thermal exceeded full value");
  chk_zero_trip: assert property (@(posedge i_clock) disable iff (!i_nrst)
    q.restored && q.cause == C_NONE && i_start && i_line_pct == 8'h00
    |=> q.cause == C_ZEROVOLT)
    else $error("zero voltage did not trip at once");
  chk_ov_floor: assert property (@(posedge i_clock) disable iff (!i_nrst)
    ov_eff >= uv_eff && ov_eff >= OV_MIN_PCT && ov_eff <= OV_MAX_PCT)
    else $error("over-voltage threshold out of range");
  chk_lock_refuse: assert property (@(posedge i_clock) disable iff (!i_nrst)
    q.st == ST_IDLE && i_store_req && i_lock |=> o_lock_refusal_message && !o_store_write)
    else $error("locked store not refused");
  chk_ramp_refuse: assert property (@(posedge i_clock) disable iff (!i_nrst)
    q.st == ST_IDLE && i_store_req && !i_lock && i_ramp_active
    |=> o_ramp_refusal_message && !o_store_write ##1 !o_store_write)
    else $error("store during ramp not refused");
  chk_store_result: assert property (@(posedge i_clock) disable iff (!i_nrst)
    q.st == ST_WAIT && i_store_done
    |=> o_save_ok_message == $past(i_store_ok) && o_save_failure_message != $past(i_store_ok))
    else $error("store result message wrong");
  chk_heat_trip: assert property (@(posedge i_clock) disable iff (!i_nrst)
    q.restored && q.cause == C_NONE && heat_trip && !zero_trip |=> q.cause == C_HEATSINK)
    else $error("heatsink over temperature did not trip");
  chk_fault_outputs: assert property (@(posedge i_clock) disable iff (!i_nrst)
    $rose(o_fault_led) |-> o_fire_inhibit && o_fault_relay && $past(trip_cause) == o_fault_cause
    || !$past(q.restored))
    else $error("fault latch outputs inconsistent");
  chk_reset_blocked: assert property (@(posedge i_clock) disable iff (!i_nrst)
    q.restored && q.cause != C_NONE && i_start |=> $stable(q.cause))
    else $error("fault cleared with start present");
  chk_pulse_level: assert property (@(posedge i_clock) disable iff (!i_nrst)
    q.pulse_on |-> o_voltage_ref_pct == PULSE_PCT && o_current_limit_off)
    else $error("pulse start level wrong");
endmodule

// ---- dv/motor_stage_model.sv ----
`timescale 1ns/10ps
module motor_stage_model (
  input wire logic i_clock,
  input wire logic i_fire_inhibit,
  input wire logic i_store_write,
  input wire logic i_store_fail,
  input wire logic [9:0] i_demand_pct,
  output logic [9:0] o_current_pct,
  output logic o_store_done,
  output logic o_store_ok
);
  logic [2:0] wait_q;
  logic sampled_write;
  // No firing means no motor current
  assign o_current_pct = i_fire_inhibit ? 10'h000 : i_demand_pct;
  initial begin
    wait_q = 3'h0;
    o_store_done = 1'b0;
    o_store_ok = 1'b0;
  end
  // Storage answers a few cycles after the write pulse; ok toggles outside done
  always @(posedge i_clock) begin
    sampled_write = i_store_write;
    #1;
    o_store_done = 1'b0;
    o_store_ok = ~o_store_ok;
    if (wait_q == 3'h1) begin
      o_store_done = 1'b1;
      o_store_ok = ~i_store_fail;
    end
    if (wait_q != 3'h0) wait_q = wait_q - 3'h1;
    if (sampled_write) wait_q = 3'h3;
  end
endmodule

// ---- dv/tb_motor_protection_fault_supervisor.sv ----
`timescale 1ns/10ps
module tb_motor_protection_fault_supervisor;
  import mps_pkg::*;
  logic clock = 1'b0;
  logic nrst, energized, start, ramp_active, run, phase_missing, seq_wrong, seq_enable;
  logic wiring_fault, aux_closed, aux_ext, aux_remote, reset_key, auto_reset_en, lock;
  logic store_req, store_fail, store_done, store_ok;
  logic [7:0] line_pct, freq_hz, heatsink_c, uv_pct, ov_pct, init_v_pct;
  logic [3:0] saved_cause, ol_delay_s, uv_delay_s, ov_delay_s, pulse_ds, cause;
  logic [9:0] demand_pct, current_pct;
  logic [8:0] init_i_pct, vref, init_i_out;
  logic led, relay, inhibit, store_write, save_ok, save_fail, lock_msg, ramp_msg;
  logic lim_off, ic_mode;
  logic [31:0] thermal;
  int failures = 0;
  int compares = 0;
  always #5 clock = ~clock;
  motor_protection_fault_supervisor #(.CS_CYCLES_P(10)) i_motor_protection_fault_supervisor (
    .i_clock(clock), .i_nrst(nrst), .i_energized(energized), .i_start(start),
    .i_ramp_active(ramp_active), .i_run(run), .i_line_pct(line_pct), .i_freq_hz(freq_hz),
    .i_phase_missing(phase_missing), .i_seq_wrong(seq_wrong), .i_seq_enable(seq_enable),
    .i_wiring_fault(wiring_fault), .i_heatsink_c(heatsink_c), .i_current_pct(current_pct),
    .i_aux_closed(aux_closed), .i_aux_ext_fault_mode(aux_ext),
    .i_aux_remote_reset_mode(aux_remote), .i_reset_key(reset_key),
    .i_auto_reset_en(auto_reset_en), .i_saved_cause(saved_cause), .i_ol_delay_s(ol_delay_s),
    .i_uv_pct(uv_pct), .i_uv_delay_s(uv_delay_s), .i_ov_pct(ov_pct),
    .i_ov_delay_s(ov_delay_s), .i_lock(lock), .i_store_req(store_req),
    .i_store_done(store_done), .i_store_ok(store_ok), .i_pulse_ds(pulse_ds),
    .i_init_v_pct(init_v_pct), .i_init_i_pct(init_i_pct), .o_fault_cause(cause),
    .o_fault_led(led), .o_fault_relay(relay), .o_fire_inhibit(inhibit), .o_thermal(thermal),
    .o_store_write(store_write), .o_save_ok_message(save_ok),
    .o_save_failure_message(save_fail), .o_lock_refusal_message(lock_msg),
    .o_ramp_refusal_message(ramp_msg), .o_voltage_ref_pct(vref),
    .o_current_limit_off(lim_off), .o_init_current_mode(ic_mode),
    .o_init_current_pct(init_i_out)
  );
  motor_stage_model i_motor_stage_model (
    .i_clock(clock), .i_fire_inhibit(inhibit), .i_store_write(store_write),
    .i_store_fail(store_fail), .i_demand_pct(demand_pct), .o_current_pct(current_pct),
    .o_store_done(store_done), .o_store_ok(store_ok)
  );
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %0h want %0h", $time, what, got, exp);
    end
  endtask
  task automatic clear_fault;
    reset_key = 1'b1;
    tick(2);
    reset_key = 1'b0;
    tick(1);
    check(cause, C_NONE, "clear by key");
  endtask
  task automatic tally_and_finish;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic test_restore;
    nrst = 1'b0;
    saved_cause = C_HEATSINK;
    tick(2);
    nrst = 1'b1;
    tick(3);
    check(cause, C_HEATSINK, "restored cause");
    saved_cause = C_NONE;
    clear_fault();
    $display("test restore done");
  endtask
  task automatic test_heatsink;
    heatsink_c = 8'h55;
    tick(5);
    check(cause, C_NONE, "heat at limit");
    heatsink_c = 8'h56;
    tick(3);
    check(cause, C_HEATSINK, "heat over limit");
    check({led, relay, inhibit}, 3'b111, "fault outputs");
    reset_key = 1'b1;
    tick(3);
    check(cause, C_HEATSINK, "reset while hot");
    reset_key = 1'b0;
    heatsink_c = 8'h28;
    tick(1);
    clear_fault();
    check({led, relay, inhibit}, 3'b000, "outputs cleared");
    $display("test heatsink done");
  endtask
  task automatic test_voltage;
    start = 1'b1;
    line_pct = 8'h00;
    tick(3);
    check(cause, C_ZEROVOLT, "zero volt");
    line_pct = 8'h64;
    reset_key = 1'b1;
    tick(3);
    check(cause, C_ZEROVOLT, "reset with start");
    reset_key = 1'b0;
    start = 1'b0;
    tick(1);
    clear_fault();
    start = 1'b1;
    uv_delay_s = 4'h2;
    line_pct = 8'h4F;
    tick(1500);
    line_pct = 8'h64;
    tick(10);
    line_pct = 8'h4F;
    tick(1500);
    check(cause, C_NONE, "uv restarted");
    tick(1600);
    check(cause, C_UNDERVOLT, "uv trip");
    line_pct = 8'h64;
    start = 1'b0;
    clear_fault();
    line_pct = 8'h73;
    tick(1100);
    check(cause, C_NONE, "ov at level");
    line_pct = 8'h74;
    tick(2100);
    check(cause, C_OVERVOLT, "ov trip");
    line_pct = 8'h64;
    clear_fault();
    $display("test voltage done");
  endtask
  task automatic test_supply;
    logic [7:0] f [4] = '{8'h2C, 8'h2D, 8'h41, 8'h42};
    for (int k = 0; k < 4; k++) begin
      freq_hz = f[k];
      tick(3);
      check(cause, (k == 0 || k == 3) ? C_FREQUENCY : C_NONE, "frequency");
      freq_hz = 8'h32;
      tick(1);
      if (k == 0 || k == 3) clear_fault();
    end
    energized = 1'b0;
    phase_missing = 1'b1;
    tick(1100);
    check(cause, C_NONE, "phase loss off");
    energized = 1'b1;
    tick(2100);
    check(cause, C_PHASE_LOSS, "phase loss");
    auto_reset_en = 1'b1;
    phase_missing = 1'b0;
    tick(59900);
    check(cause, C_PHASE_LOSS, "auto reset early");
    tick(1200);
    check(cause, C_NONE, "auto reset");
    auto_reset_en = 1'b0;
    clear_fault();
    seq_wrong = 1'b1;
    tick(5);
    check(cause, C_NONE, "sequence off");
    seq_enable = 1'b1;
    tick(3);
    check(cause, C_SEQUENCE, "sequence on");
    seq_wrong = 1'b0;
    clear_fault();
    $display("test supply done");
  endtask
  task automatic test_wiring_aux;
    wiring_fault = 1'b1;
    tick(5);
    check(cause, C_NONE, "wiring no start");
    start = 1'b1;
    tick(3);
    check(cause, C_WIRING, "wiring trip");
    wiring_fault = 1'b0;
    start = 1'b0;
    clear_fault();
    aux_ext = 1'b1;
    aux_closed = 1'b1;
    tick(1900);
    check(cause, C_NONE, "aux early");
    tick(1200);
    check(cause, C_EXTERNAL, "aux trip");
    aux_closed = 1'b0;
    aux_ext = 1'b0;
    clear_fault();
    aux_remote = 1'b1;
    heatsink_c = 8'h60;
    tick(3);
    heatsink_c = 8'h28;
    aux_closed = 1'b1;
    tick(3);
    aux_closed = 1'b0;
    tick(1);
    check(cause, C_NONE, "remote reset");
    aux_remote = 1'b0;
    $display("test wiring aux done");
  endtask
  task automatic test_overload;
    ramp_active = 1'b1;
    demand_pct = 10'h1F4;
    tick(300);
    check(thermal, 32'h0, "no heating in ramp");
    ramp_active = 1'b0;
    run = 1'b1;
    tick(1000);
    check(cause, C_NONE, "overload early");
    tick(200);
    check(cause, C_OVERLOAD, "overload trip");
    run = 1'b0;
    demand_pct = 10'h064;
    clear_fault();
    $display("test overload done");
  endtask
  task automatic do_store(input logic l, input logic r, input logic f, input logic [3:0] m,
                          input int exp_writes);
    int writes;
    writes = 0;
    lock = l;
    ramp_active = r;
    store_fail = f;
    store_req = 1'b1;
    tick(1);
    store_req = 1'b0;
    repeat (20) begin
      if (store_write === 1'b1) writes++;
      tick(1);
    end
    check(writes, exp_writes, "store writes");
    check({save_ok, save_fail, lock_msg, ramp_msg}, m, "store messages");
    lock = 1'b0;
    ramp_active = 1'b0;
    tick(1);
  endtask
  task automatic test_store;
    do_store(1'b1, 1'b0, 1'b0, 4'h2, 0);
    do_store(1'b0, 1'b1, 1'b0, 4'h1, 0);
    do_store(1'b0, 1'b0, 1'b0, 4'h8, 1);
    do_store(1'b0, 1'b0, 1'b1, 4'h4, 1);
    do_store(1'b1, 1'b1, 1'b0, 4'h2, 0);
    $display("test store done");
  endtask
  task automatic test_pulse;
    pulse_ds = 4'h2;
    start = 1'b1;
    tick(3);
    check(vref, PULSE_PCT, "pulse level");
    check(lim_off, 1'b1, "pulse no limit");
    tick(175);
    check(vref, PULSE_PCT, "pulse held");
    tick(40);
    check({vref, lim_off}, {9'h01E, 1'b0}, "pulse end");
    init_v_pct = 8'h05;
    tick(2);
    check(vref, INIT_V_MIN_PCT, "init volt clamp");
    init_v_pct = 8'h3C;
    init_i_pct = 9'h1C2;
    tick(2);
    check({ic_mode, init_i_out}, {1'b1, INIT_I_MAX_PCT}, "init current");
    start = 1'b0;
    init_v_pct = 8'h1E;
    $display("test pulse done");
  endtask
  initial begin
    repeat (90000) @(posedge clock);
    failures++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    {nrst, start, ramp_active, run, phase_missing, seq_wrong, seq_enable} = 7'h00;
    {wiring_fault, aux_closed, aux_ext, aux_remote, reset_key, auto_reset_en} = 6'h00;
    {lock, store_req, store_fail} = 3'h0;
    energized = 1'b1;
    line_pct = 8'h64;
    freq_hz = 8'h32;
    heatsink_c = 8'h28;
    demand_pct = 10'h064;
    saved_cause = C_NONE;
    {ol_delay_s, uv_delay_s, ov_delay_s, pulse_ds} = {4'h1, 4'h1, 4'h1, 4'h0};
    uv_pct = 8'h50;
    ov_pct = 8'h73;
    init_v_pct = 8'h1E;
    init_i_pct = 9'h0C8;
    tick(4);
    check({cause, vref}, {C_NONE, INIT_V_MIN_PCT}, "reset values");
    nrst = 1'b1;
    tick(2);
    test_heatsink();
    test_restore();
    test_voltage();
    test_supply();
    test_wiring_aux();
    test_overload();
    test_store();
    test_pulse();
    tally_and_finish();
  end
endmodule
